// ==== hdl/counter_array_pkg.sv ====
/*
 * Package for the counter array register slice: SFR addresses, reset values,
 * field positions and the packed carriers shared by the design and its bench.
 * Assumes an 8-bit special function register bus on one system clock.
 */
`default_nettype none
package counter_array_pkg;
	localparam logic [7:0] addr_output_polarity = 8'h96;
	localparam logic [7:0] addr_counter_low = 8'hF9;
	localparam logic [7:0] addr_counter_high = 8'hFA;
	localparam logic [7:0] addr_ch0_compare_low = 8'hFB;
	localparam logic [7:0] addr_ch0_compare_high = 8'hFC;
	localparam logic [7:0] reset_byte = 8'h00;
	localparam logic [2:0] reset_polarity = 3'h0;
	localparam logic [15:0] reset_word = 16'h0000;
	localparam int polarity_bits = 3;
	localparam int reserved_mask_lsb = 3;

	// One SFR bus cycle from the core
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} sfr_req_t;

	// Controls from the mode and PWM configuration registers kept elsewhere
	typedef struct packed {
		logic reload_select;
		logic count_enable;
	} array_ctrl_t;
endpackage
`default_nettype wire

// ==== hdl/counter_array_regs_polarity.sv ====
/*
 * Counter array register slice: 16-bit counter byte access with high-byte
 * snapshot, channel 0 compare/auto-reload value, compare-enable side effects
 * and per-channel output polarity. Assumes the core drives one SFR request per
 * cycle on clk and samples rdata one cycle after a read strobe.
 */
`default_nettype none

// Summary of operation
// R1: Counter bits 7:0 readable/writable as low-byte register, reset zero.
// R2: Counter bits 15:8 readable/writable as high-byte register, reset zero.
// R3: High-byte reads return snapshot loaded only when low byte is read.
// R4: Channel 0 compare value held as low and high bytes, RW, reset zero.
// R5: In 9-11 bit PWM, compare addresses also reach the auto-reload bytes.
// R6: Reload-select bit chooses compare value or auto-reload value for access.
// R7: Writing compare low byte clears channel 0 compare enable.
// R8: Writing compare high byte sets channel 0 compare enable.
// R9: Polarity bits 2:0 invert channel outputs 2:0 when set.
// R10: Polarity change reaches the output pin at once.
// R11: Software writes zero into reserved polarity bits 7:3.
// R12: Compare enable gates the channel 0 comparator.
// R13: Inversion is an XOR after mode logic, right before the pin; the XOR here feeds the pin_level register, which drives the pin.
module counter_array_regs_polarity (
	input wire logic clk,
	input wire logic srst,
	input wire counter_array_pkg::sfr_req_t sfr_req,
	input wire counter_array_pkg::array_ctrl_t ctrl,
	input wire logic [2:0] mode_output,
	output logic [7:0] sfr_rdata,
	output logic compare_enable,
	output logic ch0_match,
	output logic [15:0] ch0_reload,
	output logic ch0_output,
	output logic ch1_output,
	output logic ch2_output
);
	import counter_array_pkg::*;

	logic [15:0] counter;
	logic [7:0] high_snapshot;
	logic [15:0] ch0_compare;
	logic [2:0] polarity;
	logic [2:0] pin_level;
	logic wr_low, wr_high, wr_cl, wr_ch, wr_pol, rd_low;

	assign wr_low = sfr_req.wr && sfr_req.addr == addr_counter_low;
	assign wr_high = sfr_req.wr && sfr_req.addr == addr_counter_high;
	assign wr_cl = sfr_req.wr && sfr_req.addr == addr_ch0_compare_low;
	assign wr_ch = sfr_req.wr && sfr_req.addr == addr_ch0_compare_high;
	assign wr_pol = sfr_req.wr && sfr_req.addr == addr_output_polarity;
	assign rd_low = sfr_req.rd && sfr_req.addr == addr_counter_low;

	// A byte write replaces only its half; the other half holds and counting pauses that cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			counter <= reset_word;
		end else if (wr_low) begin
			counter <= {counter[15:8], sfr_req.wdata}; // R1
		end else if (wr_high) begin
			counter <= {sfr_req.wdata, counter[7:0]}; // R2
		end else if (ctrl.count_enable) begin
			counter <= counter + 16'h0001;
		end
	end

	// Snapshot keeps a 16-bit read coherent across the two byte reads
	always_ff @(posedge clk) begin
		if (srst) begin
			high_snapshot <= reset_byte;
		end else if (rd_low) begin
			high_snapshot <= counter[15:8]; // R3
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ch0_compare <= reset_word;
		end else if (wr_cl && !ctrl.reload_select) begin
			ch0_compare[7:0] <= sfr_req.wdata; // R4 R6
		end else if (wr_ch && !ctrl.reload_select) begin
			ch0_compare[15:8] <= sfr_req.wdata; // R4 R6
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ch0_reload <= reset_word;
		end else if (wr_cl && ctrl.reload_select) begin
			ch0_reload[7:0] <= sfr_req.wdata; // R5 R6
		end else if (wr_ch && ctrl.reload_select) begin
			ch0_reload[15:8] <= sfr_req.wdata; // R5 R6
		end
	end

	// Side effect applies whichever value the reload select steers to
	always_ff @(posedge clk) begin
		if (srst) begin
			compare_enable <= 1'b0;
		end else if (wr_cl) begin
			compare_enable <= 1'b0; // R7
		end else if (wr_ch) begin
			compare_enable <= 1'b1; // R8
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ch0_match <= 1'b0;
		end else begin
			ch0_match <= compare_enable && counter == ch0_compare; // R12
		end
	end

	// Reserved bits are not stored, so they read back as zero regardless
	always_ff @(posedge clk) begin
		if (srst) begin
			polarity <= reset_polarity;
		end else if (wr_pol) begin
			polarity <= sfr_req.wdata[polarity_bits-1:0]; // R9 R11
		end
	end

	// Inversion uses the next polarity so the pin flips on the write edge
	genvar ch;
	generate
		for (ch = 0; ch < polarity_bits; ch++) begin : g_pin
			logic next_pol;
			assign next_pol = wr_pol ? sfr_req.wdata[ch] : polarity[ch]; // R10
			always_ff @(posedge clk) begin
				if (srst) begin
					pin_level[ch] <= 1'b0;
				end else begin
					pin_level[ch] <= mode_output[ch] ^ next_pol; // R13 R9
				end
			end
		end
	endgenerate

	assign ch0_output = pin_level[0];
	assign ch1_output = pin_level[1];
	assign ch2_output = pin_level[2];

	always_ff @(posedge clk) begin
		if (srst) begin
			sfr_rdata <= reset_byte;
		end else if (sfr_req.rd) begin
			unique case (sfr_req.addr)
				addr_counter_low: sfr_rdata <= counter[7:0]; // R1
				addr_counter_high: sfr_rdata <= high_snapshot; // R3
				addr_ch0_compare_low: sfr_rdata <= ctrl.reload_select ? ch0_reload[7:0] : ch0_compare[7:0]; // R6
				addr_ch0_compare_high: sfr_rdata <= ctrl.reload_select ? ch0_reload[15:8] : ch0_compare[15:8]; // R6
				addr_output_polarity: sfr_rdata <= {5'h00, polarity};
				default: sfr_rdata <= reset_byte;
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== testbench/counter_array_props_properties.sv ====
/* Assertions on the counter array register slice ports.
   Assumes it is bound to counter_array_regs_polarity. */
`default_nettype none
module counter_array_props (
	input wire logic clk,
	input wire logic srst,
	input wire counter_array_pkg::sfr_req_t sfr_req,
	input wire logic [2:0] mode_output,
	input wire logic [7:0] sfr_rdata,
	input wire logic compare_enable,
	input wire logic ch0_match,
	input wire logic ch0_output,
	input wire logic ch1_output,
	input wire logic ch2_output
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire logic wr_fb = sfr_req.wr && sfr_req.addr == 8'hFB;
	wire logic wr_fc = sfr_req.wr && sfr_req.addr == 8'hFC;
	a_low_clears: assert property (wr_fb |=> !compare_enable) else $error("enable not cleared");
	a_high_sets: assert property (wr_fc |=> compare_enable) else $error("enable not set");
	a_en_holds: assert property (!wr_fb && !wr_fc |=> $stable(compare_enable)) else $error("enable moved");
	a_pol_pins: assert property (sfr_req.wr && sfr_req.addr == 8'h96 |=>
		{ch2_output, ch1_output, ch0_output} == $past(mode_output ^ sfr_req.wdata[2:0])) else $error("pin level");
	a_pol_read: assert property (sfr_req.rd && sfr_req.addr == 8'h96 |=> sfr_rdata[7:3] == 5'h00) else $error("pol read");
	a_unmapped_zero: assert property (sfr_req.rd && !(sfr_req.addr inside {8'h96, [8'hF9:8'hFC]}) |=>
		sfr_rdata == 8'h00) else $error("unmapped read");
	a_rdata_hold: assert property (!sfr_req.rd |=> $stable(sfr_rdata)) else $error("rdata moved");
	a_match_gate: assert property (!compare_enable |=> !ch0_match) else $error("match while disabled");
	c_low_read: cover property (sfr_req.rd && sfr_req.addr == 8'hF9);
	c_match: cover property (ch0_match);
	c_pol_write: cover property (sfr_req.wr && sfr_req.addr == 8'h96);
endmodule
bind counter_array_regs_polarity counter_array_props counter_array_props_inst (.clk, .srst, .sfr_req,
	.mode_output, .sfr_rdata, .compare_enable, .ch0_match, .ch0_output, .ch1_output, .ch2_output);
`default_nettype wire

// ==== testbench/core_model.sv ====
/* Core model: one SFR access per call, launched at the falling edge.
   Assumes the caller spaces accesses by whole cycles. */
`default_nettype none
module core_model (
	input wire logic clk,
	output var counter_array_pkg::sfr_req_t sfr_req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial sfr_req = '0;
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_req = '{a, d, w, !w};
		@(negedge clk);
		// Released lines show junk so stale values are never trusted
		sfr_req = '{~a, ~d, 1'b0, 1'b0};
	endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
/* Self-checking bench for the counter array register slice.
   Assumes core_model and the checker are compiled first. */
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import counter_array_pkg::*;
	logic clk = 0, srst = 1, rd_d = 0, en, match, o0, o1, o2;
	sfr_req_t req;
	array_ctrl_t ctrl = '0;
	logic [2:0] mo = 0;
	logic [7:0] rdata;
	logic [15:0] rl;
	logic [7:0] expq[$];
	int fail_count = 0, num_checks = 0;
	initial forever #5 clk = ~clk;
	core_model core_model_inst (.clk(clk), .sfr_req(req));
	counter_array_regs_polarity counter_array_regs_polarity_inst (.clk(clk), .srst(srst), .sfr_req(req),
		.ctrl(ctrl), .mode_output(mo), .sfr_rdata(rdata), .compare_enable(en), .ch0_match(match),
		.ch0_reload(rl), .ch0_output(o0), .ch1_output(o1), .ch2_output(o2));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		core_model_inst.access(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expq.push_back(e);
		core_model_inst.access(1'b0, a, 8'h00);
	endtask
	always @(posedge clk) begin
		rd_d <= req.rd;
		if (rd_d && expq.size() > 0)
			chk(rdata, expq.pop_front());
	end
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		logic [7:0] x, y;
		logic [2:0] p;
		void'($urandom(56551));
		repeat (3) @(negedge clk);
		srst = 0;
		wr(8'hFA, 8'hAB);
		wr(8'hF9, 8'hCD);
		rd(8'hF9, 8'hCD);
		wr(8'hFA, 8'h11);
		rd(8'hFA, 8'hAB);
		rd(8'hF9, 8'hCD);
		rd(8'hFA, 8'h11);
		$display("counter test done");
		wr(8'hFB, 8'hCD);
		chk(en, 0);
		wr(8'hFC, 8'h11);
		@(negedge clk);
		chk({en, match}, 3);
		wr(8'hFB, 8'hCD);
		@(negedge clk);
		chk({en, match}, 0);
		x = 8'($urandom);
		y = 8'($urandom);
		ctrl.reload_select = 1;
		wr(8'hFB, x);
		wr(8'hFC, y);
		chk(rl, {y, x});
		rd(8'hFB, x);
		ctrl.reload_select = 0;
		rd(8'hFB, 8'hCD);
		rd(8'hFC, 8'h11);
		$display("compare test done");
		repeat (4) begin
			p = 3'($urandom);
			mo = 3'($urandom);
			wr(8'h96, {5'h00, p});
			chk({o2, o1, o0}, mo ^ p);
			rd(8'h96, {5'h00, p});
		end
		rd(8'h97, 8'h00);
		$display("polarity test done");
		repeat (2) @(negedge clk);
		wrap_up;
	end
	initial begin
		#100000;
		fail_count++;
		wrap_up;
	end
endmodule
`default_nettype wire
